// file: idx_set_unit.sv
// Decode and execute unit for indexed bit set and byte fill instructions
//
// Operation
// - Opcode 1000 bbb0 kkkkkkkk sets bit b
// - Opcode 0110 1000 kkkkkkkk writes FFh
// - Offset 0..95, added to full pointer
// - One word, one cycle, flags untouched
// - Config bit zero disables extended set
// - Enabled: operands up to 5Fh are offsets
module idx_set_unit
  import idx_set_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Configuration
  input  wire logic              extended_set_config_bit,
  // Instruction stream, one word per instruction cycle
  input  wire logic              insn_valid,
  input  wire logic [INSN_W-1:0] insn_word,
  input  wire logic [ADDR_W-1:0] stack_frame_pointer,
  // Data memory
  output logic                   mem_rd_en,
  output logic                   mem_wr_en,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_wr_data,
  input  wire logic [DATA_W-1:0] mem_rd_data,
  // Status to the core
  output logic                   insn_claimed,
  output logic                   insn_done,
  output logic                   phase_busy
);

  // --------------------------------------------------------------
  // Width check
  // --------------------------------------------------------------
  // Decode uses fixed bit positions, other widths are refused
  if (ADDR_W != 12 || DATA_W != 8 || INSN_W != 16)
  begin : g_width_check
    $error("idx_set_unit: unsupported widths");
  end

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  function automatic logic [DATA_W-1:0] bit_mask(
    input logic [BIT_SEL_W-1:0] sel
  );
    bit_mask = DATA_W'(1) << sel;
  endfunction : bit_mask

  wire logic       is_bitset = insn_word[15:12] == BIT_SET_NIB
                               && !insn_word[FLAG_BIT_POS];
  wire logic       is_fill   = insn_word[15:8] == BYTE_FILL_HI;
  wire logic       op_match  = is_bitset || is_fill;

  // --------------------------------------------------------------
  // Offset and address
  // --------------------------------------------------------------
  // Operands above the limit stay absolute and are not ours
  wire logic [7:0] offset_k  = insn_word[7:0];
  wire logic       off_ok    = offset_k <= OFFSET_MAX;
  // Full pointer plus offset; wraps at the top of data space
  wire logic [ADDR_W-1:0] eff_addr =
    stack_frame_pointer + ADDR_W'(offset_k);

  // --------------------------------------------------------------
  // Claim
  // --------------------------------------------------------------
  // Config bit low leaves every word to the base decoder
  wire logic       ext_on    = extended_set_config_bit;
  wire logic       hit       = insn_valid && ext_on && off_ok
                               && op_match;
  wire op_kind_t   dec_kind  = !hit ? OP_NONE :
                               (is_bitset ? OP_BIT_SET : OP_BYTE_FILL);

  // --------------------------------------------------------------
  // Phase sequencer
  // --------------------------------------------------------------
  phase_t                 phase_r;
  phase_t                 phase_nxt;
  op_kind_t               kind_r;
  logic [BIT_SEL_W-1:0]   bsel_r;

  always_comb
  begin
    unique case (phase_r)
      PH_DECODE: phase_nxt = (dec_kind != OP_NONE) ? PH_READ : PH_DECODE;
      PH_READ:   phase_nxt = PH_MODIFY;
      PH_MODIFY: phase_nxt = PH_WRITE;
      PH_WRITE:  phase_nxt = PH_DECODE;
    endcase
  end

  // --------------------------------------------------------------
  // Phase qualifiers
  // --------------------------------------------------------------
  // Words seen outside the idle phase are ignored
  wire logic take_insn = (phase_r == PH_DECODE)
                         && (dec_kind != OP_NONE);
  wire logic in_modify = (phase_r == PH_MODIFY);
  wire logic in_write  = (phase_r == PH_WRITE);

  // --------------------------------------------------------------
  // Modify
  // --------------------------------------------------------------
  // Read byte stands only in the third phase, so it is used there
  // No status flag is touched
  wire logic [DATA_W-1:0] mod_data = (kind_r == OP_BIT_SET)
                                     ? (mem_rd_data | bit_mask(bsel_r))
                                     : FILL_VALUE;

  // --------------------------------------------------------------
  // Sequencer registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      phase_r <= PH_DECODE;
    else
      phase_r <= phase_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kind_r <= OP_NONE;
      bsel_r <= '0;
    end
    else if (take_insn)
    begin
      kind_r <= dec_kind;
      bsel_r <= insn_word[BIT_SEL_LSB +: BIT_SEL_W];
    end
    else if (in_write)
    begin
      kind_r <= OP_NONE;
    end
  end

  // --------------------------------------------------------------
  // Memory port
  // --------------------------------------------------------------
  // Address holds from claim until the next claim
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_addr <= ADDR_RESET;
    end
    else if (take_insn)
    begin
      mem_addr <= eff_addr;
    end
  end

  // Read strobe in the second phase
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mem_rd_en <= 1'b0;
    else
      mem_rd_en <= take_insn;
  end

  // Write strobe and data in the fourth phase
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mem_wr_en <= 1'b0;
    else
      mem_wr_en <= in_modify;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_wr_data <= DATA_RESET;
    end
    else if (in_modify)
    begin
      mem_wr_data <= mod_data;
    end
  end

  // --------------------------------------------------------------
  // Status outputs
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      insn_claimed <= 1'b0;
    else
      insn_claimed <= take_insn;
  end

  // Done after write back: one instruction cycle in all
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      insn_done <= 1'b0;
    else
      insn_done <= in_write;
  end

  // Busy from claim until done
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_busy <= 1'b0;
    end
    else if (take_insn)
    begin
      phase_busy <= 1'b1;
    end
    else if (in_write)
    begin
      phase_busy <= 1'b0;
    end
  end

endmodule : idx_set_unit

// file: idx_set_pkg.sv
// Constants for the indexed literal offset bit set / byte fill unit
package idx_set_pkg;
  localparam int          INSN_W        = 16;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 8;
  localparam logic [3:0]  BIT_SET_NIB   = 4'h8;
  localparam logic [7:0]  BYTE_FILL_HI  = 8'h68;
  localparam logic [7:0]  FILL_VALUE    = 8'hff;
  localparam logic [7:0]  OFFSET_MAX    = 8'h5f;
  localparam int          BIT_SEL_LSB   = 9;
  localparam int          BIT_SEL_W     = 3;
  localparam int          FLAG_BIT_POS  = 8;
  localparam logic [11:0] ADDR_RESET    = 12'h000;
  localparam logic [7:0]  DATA_RESET    = 8'h00;

  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_MODIFY,
    PH_WRITE
  } phase_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_BIT_SET,
    OP_BYTE_FILL
  } op_kind_t;
endpackage : idx_set_pkg

// file: idx_set_assertions.sv
// Port checks for the indexed bit set / byte fill unit
module idx_set_assertions
  import idx_set_pkg::*;
(
  // All unit ports
  input wire logic clk_sys, rst_n, extended_set_config_bit, insn_valid,
  input wire logic [INSN_W-1:0] insn_word,
  input wire logic [ADDR_W-1:0] stack_frame_pointer, mem_addr,
  input wire logic [DATA_W-1:0] mem_wr_data, mem_rd_data,
  input wire logic mem_rd_en, mem_wr_en, insn_claimed, insn_done, phase_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  AST_CLAIM_READ: assert property (insn_claimed |-> mem_rd_en)
    else $error("claim without read");
  AST_WRITE_SLOT: assert property (insn_claimed |-> ##2 mem_wr_en)
    else $error("write not in fourth phase");
  AST_ONE_CYCLE: assert property (insn_claimed |-> ##3 insn_done)
    else $error("done late");
  AST_BUSY_SPAN: assert property
    (insn_claimed |-> phase_busy[*3] ##1 !phase_busy) else $error("busy span");
  AST_CFG_OFF: assert property
    (!extended_set_config_bit |=> !insn_claimed)
    else $error("claimed while disabled");
  AST_FILL_DATA: assert property (insn_claimed &&
    $past(insn_word[15:8]) == BYTE_FILL_HI |-> ##2 mem_wr_data == FILL_VALUE)
    else $error("fill data");
  AST_ADDR_SUM: assert property (insn_claimed |-> mem_addr ==
    $past(stack_frame_pointer) + $past(insn_word[7:0])) else $error("addr");
  AST_OFFSET_LIM: assert property
    (insn_claimed |-> $past(insn_word[7:0]) <= OFFSET_MAX)
    else $error("offset");
  cover property (insn_done);
  cover property (mem_wr_en && mem_wr_data != FILL_VALUE);
  cover property (mem_wr_en && mem_wr_data == FILL_VALUE);
  cover property (insn_valid && !extended_set_config_bit);
endmodule : idx_set_assertions
bind idx_set_unit idx_set_assertions i_idx_set_assertions (.*);

// file: idx_mem_model.sv
// Data memory model behind the indexed set unit
module idx_mem_model
  import idx_set_pkg::*;
(
  // Memory bus
  input  wire logic              clk_sys, mem_rd_en, mem_wr_en,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [DATA_W-1:0] mem_wr_data,
  output logic      [DATA_W-1:0] mem_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  initial mem_rd_data = 8'h00;
  // Read data valid one cycle, scrambled after
  always @(posedge clk_sys)
  begin
    mem_rd_data <= mem_rd_en ? mem[mem_addr] : ~mem_rd_data;
    if (mem_wr_en)
      mem[mem_addr] <= mem_wr_data;
  end
endmodule : idx_mem_model

// file: tb_top.sv
// Testbench for the indexed bit set / byte fill unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import idx_set_pkg::*;
  logic clk_sys = 0, rst_n = 0, extended_set_config_bit = 1, insn_valid = 0;
  logic [INSN_W-1:0] insn_word = '0;
  logic [ADDR_W-1:0] stack_frame_pointer = '0, mem_addr;
  logic [DATA_W-1:0] mem_rd_data, mem_wr_data;
  logic mem_rd_en, mem_wr_en, insn_claimed, insn_done, phase_busy;
  int fails = 0, n_tests = 0, nd, nc, nb;
  idx_set_unit i_idx_set_unit (.*);
  idx_mem_model i_idx_mem_model (.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(string nm, logic [11:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic run(logic [15:0] w, logic [11:0] fp);
    @(negedge clk_sys);
    insn_word = w;
    stack_frame_pointer = fp;
    insn_valid = 1;
    nd = 0;
    nc = 0;
    nb = 0;
    repeat (7)
    begin
      @(negedge clk_sys);
      insn_valid = 0;
      nd += (insn_done === 1'b1);
      nc += (insn_claimed === 1'b1);
      nb += (phase_busy === 1'b1);
    end
  endtask : run
  task automatic t_set_fill();
    logic [7:0] got;
    for (int b = 0; b < 8; b++)
    begin
      i_idx_mem_model.mem[12'ha5f] = 8'h55;
      run({4'h8, 3'(b), 1'b0, 8'h5f}, 12'ha00);
      got = i_idx_mem_model.mem[12'ha5f];
      chk("bit", 12'(got), 12'(8'h55 | 1 << b));
      chk("done", 12'(nd), 12'h001);
      chk("claim", 12'(nc), 12'h001);
      chk("busy", 12'(nb), 12'h003);
    end
    i_idx_mem_model.mem[12'h000] = 8'h00;
    run(16'h6801, 12'hfff);
    chk("fill", 12'(i_idx_mem_model.mem[12'h000]), 12'h0ff);
    chk("done", 12'(nd), 12'h001);
  endtask : t_set_fill
  task automatic t_refuse();
    logic [15:0] w [3] = '{16'h6860, 16'h8110, 16'h6810};
    logic [11:0] a;
    for (int i = 0; i < 3; i++)
    begin
      extended_set_config_bit = (i < 2);
      a = 12'h200 + 12'(w[i][7:0]);
      i_idx_mem_model.mem[a] = 8'h3c;
      run(w[i], 12'h200);
      chk("refused", 12'(nd), 12'h000);
      chk("no claim", 12'(nc), 12'h000);
      chk("kept", 12'(i_idx_mem_model.mem[a]), 12'h03c);
    end
    extended_set_config_bit = 1;
  endtask : t_refuse
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1;
    t_set_fill();
    t_refuse();
    end_of_test();
  end
endmodule : tb_top
